// ### hw/adc_port_regs.svh
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

// Pin bus widths
`define ADC_BUS_W        12
`define ADC_BYTE_W       8
`define ADC_CTRL_W       12
// Conversion length in master-clock rising edges
`define ADC_CONV_EDGES   13
// Extra fixed delay after the last edge, in ns, and its count of 40 ns cycles
`define ADC_T2_NS        40
`define ADC_CLK_NS       40
`define ADC_T2_CYC       ((`ADC_T2_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
// High byte layout
`define ADC_HI_NIB_LSB   0
`define ADC_HI_ID_LSB    4
// Host register offsets (byte addresses)
`define HOST_REG_CTRL    4'h0
`define HOST_REG_WDATA   4'h4
`define HOST_REG_STATUS  4'h8
`define HOST_REG_RESULT  4'hC
// Host control word bits
`define HOST_CMD_CONV    0
`define HOST_CMD_READ    1
`define HOST_CMD_WRITE   2
`define HOST_CMD_WORD    3
`define HOST_CMD_CLKRUN  4
`define HOST_CMD_WAKE    5

`endif

// ### hw/adc_port_pkg.sv
package adc_port_pkg;
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN,
        CONV_TAIL
    } conv_state_t;

    typedef enum logic [2:0] {
        HOST_IDLE,
        HOST_SETUP,
        HOST_STROBE,
        HOST_HIGH,
        HOST_RECOVER
    } host_state_t;

    typedef logic [11:0] bus_word_t;
endpackage

// ### hw/adc_port_if.sv
interface adc_port_if;
    logic [11:0] data_from_host;
    logic [11:0] data_from_dev;
    logic [11:0] data_oe_n_host;
    logic [11:0] data_oe_n_dev;
    logic        word_mode;
    logic        chip_select_n;
    logic        read_n;
    logic        write_n;
    logic        conversion_start_n;
    logic        master_clock_in;
    logic        busy;
    logic [11:0] data_bus;

    // Wire level from both ends; undriven lines pull low
    genvar gi;
    for (gi = 0; gi < 12; gi++) begin : g_bus
        assign data_bus[gi] = (!data_oe_n_dev[gi] && data_from_dev[gi]) ||
                              (!data_oe_n_host[gi] && data_from_host[gi]);
    end

    modport dev (
        input  data_bus, word_mode, chip_select_n, read_n, write_n,
               conversion_start_n, master_clock_in,
        output data_from_dev, data_oe_n_dev, busy
    );
    modport host (
        input  data_bus, busy,
        output data_from_host, data_oe_n_host, word_mode, chip_select_n, read_n, write_n,
               conversion_start_n, master_clock_in
    );
endinterface

// ### hw/adc_port_dev.sv
`include "adc_port_regs.svh"
module adc_port_dev #(
    parameter int RES_BITS = 12
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    adc_port_if.dev                     port,
    input  wire adc_port_pkg::bus_word_t sample_i,
    input  wire logic                   auto_power_down_i,
    output logic [11:0]                 ctrl_o,
    output logic [1:0]                  channel_o,
    output logic                        tracking_o,
    output logic                        powered_o
);
    import adc_port_pkg::*;

    localparam int LOW_ZERO = 12 - RES_BITS;

    conv_state_t state_r;
    logic        start_d_r;
    logic        mclk_d_r;
    logic [3:0]  edge_cnt_r;
    logic [3:0]  tail_cnt_r;
    bus_word_t   result_r;
    logic [1:0]  result_id_r;
    logic [11:0] ctrl_r;
    logic        tracking_r;
    logic        powered_r;
    logic        busy_r;
    logic        wr_d_r;
    bus_word_t   dout_r;
    logic [11:0] oe_n_r;

    logic start_fall;
    logic start_rise;
    logic mclk_rise;
    logic selected_read;
    logic selected_write;
    logic high_byte;

    assign start_fall     = start_d_r && !port.conversion_start_n;
    assign start_rise     = !start_d_r && port.conversion_start_n;
    // Edges counted only when seen, so a burst clock works as well
    assign mclk_rise      = !mclk_d_r && port.master_clock_in;
    assign selected_read  = !port.chip_select_n && !port.read_n;
    assign selected_write = !port.chip_select_n && !port.write_n;
    assign high_byte      = !port.word_mode && port.data_bus[8];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_d_r <= 1'b1;
            mclk_d_r  <= 1'b0;
            wr_d_r    <= 1'b0;
        end else begin
            start_d_r <= port.conversion_start_n;
            mclk_d_r  <= port.master_clock_in;
            wr_d_r    <= selected_write;
        end
    end

    // Power: wake on start rising edge in auto power-down modes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            powered_r <= 1'b1;
        end else if (auto_power_down_i && state_r == CONV_IDLE && !busy_r && powered_r && start_rise) begin
            powered_r <= 1'b1;
        end else if (!powered_r && start_rise) begin
            powered_r <= 1'b1;
        end else if (auto_power_down_i && state_r == CONV_TAIL && tail_cnt_r == 4'(`ADC_T2_CYC - 1)) begin
            powered_r <= 1'b0;
        end
    end

    // Conversion sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= CONV_IDLE;
            edge_cnt_r <= 4'h0;
            tail_cnt_r <= 4'h0;
            tracking_r <= 1'b1;
            busy_r     <= 1'b0;
        end else begin
            unique case (state_r)
                CONV_IDLE: begin
                    if (start_fall && powered_r) begin
                        state_r    <= CONV_RUN;
                        tracking_r <= 1'b0;
                        busy_r     <= 1'b1;
                        edge_cnt_r <= 4'h0;
                    end
                end
                CONV_RUN: begin
                    if (mclk_rise) begin
                        edge_cnt_r <= edge_cnt_r + 4'h1;
                        if (edge_cnt_r == 4'(`ADC_CONV_EDGES - 1)) begin
                            tracking_r <= 1'b1;
                            tail_cnt_r <= 4'h0;
                            state_r    <= CONV_TAIL;
                        end
                    end
                end
                CONV_TAIL: begin
                    tail_cnt_r <= tail_cnt_r + 4'h1;
                    if (tail_cnt_r == 4'(`ADC_T2_CYC - 1)) begin
                        busy_r  <= 1'b0;
                        state_r <= CONV_IDLE;
                    end
                end
                default: state_r <= CONV_IDLE;
            endcase
        end
    end

    // Result loads on the same clock edge that busy falls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_r    <= 12'h000;
            result_id_r <= 2'h0;
        end else if (state_r == CONV_TAIL && tail_cnt_r == 4'h0) begin
            result_r    <= sample_i & ~bus_word_t'((1 << LOW_ZERO) - 1);
            result_id_r <= ctrl_r[1:0];
        end
    end

    // Control register writes; word or two bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= 12'h000;
        end else if (wr_d_r && !selected_write) begin
            if (port.word_mode) begin
                ctrl_r <= port.data_bus;
            end else if (high_byte) begin
                ctrl_r[11:8] <= port.data_bus[3:0];
            end else begin
                ctrl_r[7:0] <= port.data_bus[7:0];
            end
        end
    end

    // Read data path and output enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dout_r <= 12'h000;
            oe_n_r <= 12'hFFF;
        end else if (selected_read) begin
            if (port.word_mode) begin
                dout_r <= result_r;
                oe_n_r <= 12'h000;
            end else begin
                // Pin 8 stays an input in byte mode
                oe_n_r <= 12'hF00;
                if (high_byte) begin
                    dout_r <= {4'h0, 2'b00, result_id_r, result_r[11:8]};
                end else begin
                    dout_r <= {4'h0, result_r[7:0]};
                end
            end
        end else begin
            oe_n_r <= 12'hFFF;
        end
    end

    assign port.data_from_dev = dout_r;
    assign port.data_oe_n_dev = oe_n_r;
    assign port.busy          = busy_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_o     <= 12'h000;
            channel_o  <= 2'h0;
            tracking_o <= 1'b1;
            powered_o  <= 1'b1;
        end else begin
            ctrl_o     <= ctrl_r;
            channel_o  <= result_id_r;
            tracking_o <= tracking_r;
            powered_o  <= powered_r;
        end
    end
endmodule

// ### hw/adc_port_host.sv
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`include "adc_port_regs.svh"
module adc_port_host (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    adc_port_if.host         port,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o
);
    import adc_port_pkg::*;

    host_state_t state_r;
    logic [5:0]  cmd_r;
    logic [11:0] wdata_r;
    logic [11:0] result_r;
    logic [1:0]  id_r;
    logic        pending_r;
    logic        is_write_r;
    logic        hi_phase_r;
    logic        conv_n_r;
    logic        wake_r;
    logic        mclk_r;
    logic [11:0] dout_r;
    logic [11:0] oe_n_r;
    logic        cs_n_r;
    logic        rd_n_r;
    logic        wr_n_r;
    logic        high_byte_enable_r;
    logic        hold_r;

    // Wishbone slave: one wait state, ack for one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o   <= 1'b0;
            dat_o   <= 32'h0000_0000;
            cmd_r   <= 6'h00;
            wdata_r <= 12'h000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (state_r == HOST_IDLE && !pending_r) begin
                cmd_r[`HOST_CMD_CONV]  <= 1'b0;
                cmd_r[`HOST_CMD_READ]  <= 1'b0;
                cmd_r[`HOST_CMD_WRITE] <= 1'b0;
                cmd_r[`HOST_CMD_WAKE]  <= 1'b0;
            end
            if (cyc_i && stb_i && !ack_o) begin
                dat_o <= 32'h0000_0000;
                if (we_i) begin
                    if (adr_i == `HOST_REG_CTRL && sel_i[0]) cmd_r <= dat_i[5:0];
                    if (adr_i == `HOST_REG_WDATA && sel_i[0]) wdata_r[7:0] <= dat_i[7:0];
                    if (adr_i == `HOST_REG_WDATA && sel_i[1]) wdata_r[11:8] <= dat_i[11:8];
                end else begin
                    unique case (adr_i)
                        `HOST_REG_CTRL:   dat_o <= {26'h0, cmd_r};
                        `HOST_REG_WDATA:  dat_o <= {20'h0, wdata_r};
                        `HOST_REG_STATUS: dat_o <= {29'h0, pending_r, state_r != HOST_IDLE, port.busy};
                        `HOST_REG_RESULT: dat_o <= {18'h0, id_r, result_r};
                        default:          dat_o <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // Master clock: free-running divide by two while enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) mclk_r <= 1'b0;
        else mclk_r <= cmd_r[`HOST_CMD_CLKRUN] ? !mclk_r : 1'b0;
    end

    // Start and wake are both one-cycle low pulses; a sleeping device ignores the fall, wakes on the rise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_n_r <= 1'b1;
            wake_r   <= 1'b0;
        end else begin
            wake_r   <= cmd_r[`HOST_CMD_WAKE];
            conv_n_r <= !((cmd_r[`HOST_CMD_CONV] && conv_n_r) || (cmd_r[`HOST_CMD_WAKE] && !wake_r));
        end
    end

    // Bus cycle sequencer; byte mode does low then high byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= HOST_IDLE;
            pending_r  <= 1'b0;
            is_write_r <= 1'b0;
            hi_phase_r <= 1'b0;
            cs_n_r     <= 1'b1;
            rd_n_r     <= 1'b1;
            wr_n_r     <= 1'b1;
            high_byte_enable_r     <= 1'b0;
            hold_r     <= 1'b0;
            oe_n_r     <= 12'hFFF;
            dout_r     <= 12'h000;
            result_r   <= 12'h000;
            id_r       <= 2'h0;
        end else begin
            unique case (state_r)
                HOST_IDLE: begin
                    if (cmd_r[`HOST_CMD_READ] || cmd_r[`HOST_CMD_WRITE]) begin
                        pending_r  <= 1'b1;
                        is_write_r <= cmd_r[`HOST_CMD_WRITE];
                        hi_phase_r <= 1'b0;
                        state_r    <= HOST_SETUP;
                    end else begin
                        pending_r <= 1'b0;
                    end
                end
                HOST_SETUP: begin
                    cs_n_r <= 1'b0;
                    high_byte_enable_r <= hi_phase_r;
                    if (is_write_r) begin
                        if (cmd_r[`HOST_CMD_WORD]) begin
                            dout_r <= wdata_r;
                            oe_n_r <= 12'h000;
                        end else begin
                            dout_r <= hi_phase_r ? {4'h0, 4'h0, wdata_r[11:8]} : {4'h0, wdata_r[7:0]};
                            oe_n_r <= 12'hE00;
                        end
                    end else begin
                        oe_n_r <= cmd_r[`HOST_CMD_WORD] ? 12'hFFF : 12'hEFF;
                    end
                    state_r <= HOST_STROBE;
                end
                HOST_STROBE: begin
                    rd_n_r  <= is_write_r;
                    wr_n_r  <= !is_write_r;
                    state_r <= HOST_HIGH;
                end
                HOST_HIGH: begin
                    // Strobe spans two edges: the device drives one clock after it sees the strobe
                    hold_r <= !hold_r;
                    if (hold_r) begin
                        if (!is_write_r) begin
                            if (cmd_r[`HOST_CMD_WORD]) result_r <= port.data_bus;
                            else if (hi_phase_r) begin
                                result_r[11:8] <= port.data_bus[3:0];
                                id_r           <= port.data_bus[5:4];
                            end else result_r[7:0] <= port.data_bus[7:0];
                        end
                        rd_n_r  <= 1'b1;
                        wr_n_r  <= 1'b1;
                        state_r <= HOST_RECOVER;
                    end
                end
                HOST_RECOVER: begin
                    cs_n_r <= 1'b1;
                    oe_n_r <= 12'hFFF;
                    if (!cmd_r[`HOST_CMD_WORD] && !hi_phase_r) begin
                        hi_phase_r <= 1'b1;
                        state_r    <= HOST_SETUP;
                    end else begin
                        state_r   <= HOST_IDLE;
                        pending_r <= 1'b0;
                    end
                end
                default: state_r <= HOST_IDLE;
            endcase
        end
    end

    assign port.data_from_host     = {dout_r[11:9], high_byte_enable_r && !cmd_r[`HOST_CMD_WORD] ? 1'b1 : dout_r[8], dout_r[7:0]};
    assign port.data_oe_n_host     = {oe_n_r[11:9], cmd_r[`HOST_CMD_WORD] ? oe_n_r[8] : 1'b0, oe_n_r[7:0]};
    assign port.word_mode          = cmd_r[`HOST_CMD_WORD];
    assign port.chip_select_n      = cs_n_r;
    assign port.read_n             = rd_n_r;
    assign port.write_n            = wr_n_r;
    assign port.conversion_start_n = conv_n_r;
    assign port.master_clock_in    = mclk_r;
endmodule

// ### dv/adc_port_props.sv
module adc_port_props (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [11:0] data_bus,
    input  wire logic [11:0] data_from_dev,
    input  wire logic [11:0] data_oe_n_dev,
    input  wire logic        word_mode,
    input  wire logic        chip_select_n,
    input  wire logic        read_n,
    input  wire logic        write_n,
    input  wire logic        conversion_start_n,
    input  wire logic        master_clock_in,
    input  wire logic        busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       start_fell_r;
    logic [4:0] mclk_cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_fell_r <= 1'b0;
        end else begin
            start_fell_r <= $fell(conversion_start_n);
        end
    end

    // Counts master-clock rises from the start fall to the busy fall
    always_ff @(posedge clk_i) begin
        if (rst_i || (!busy && !start_fell_r)) begin
            mclk_cnt_r <= 5'h00;
        end else if ($rose(master_clock_in)) begin
            mclk_cnt_r <= mclk_cnt_r + 5'h01;
        end
    end

    sequence s_read_held;
        (!chip_select_n && !read_n && word_mode) [*2];
    endsequence
    sequence s_read_recent;
        $past(!chip_select_n && !read_n, 1) || $past(!chip_select_n && !read_n, 2);
    endsequence

    a_reset_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (data_oe_n_dev == 12'hFFF) && !busy) else $error("device active after reset");
    a_float_unless_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (data_oe_n_dev != 12'hFFF) |-> s_read_recent) else $error("device drives bus without read");
    a_word_drive_all: assert property (@(posedge clk_i) disable iff (rst_i)
        s_read_held |-> (data_oe_n_dev == 12'h000)) else $error("word read not driven on all lines");
    a_no_drive_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (!chip_select_n && !write_n) |-> (data_oe_n_dev == 12'hFFF)) else $error("device drives during write");
    a_byte_upper_float: assert property (@(posedge clk_i) disable iff (rst_i)
        (!word_mode && (data_oe_n_dev != 12'hFFF)) |-> (data_oe_n_dev[11:8] == 4'hF))
        else $error("byte mode drives upper lines");
    a_high_byte_zeros: assert property (@(posedge clk_i) disable iff (rst_i)
        (!word_mode && data_bus[8] && (data_oe_n_dev[7:0] == 8'h00)) |-> (data_from_dev[7:6] == 2'b00))
        else $error("high byte top bits not zero");
    a_busy_after_start: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(busy) |-> start_fell_r) else $error("busy rose without start fall");
    a_busy_span: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(busy) |-> (mclk_cnt_r inside {[13:14]})) else $error("conversion length wrong");
    a_busy_ends: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(busy) |-> ##[1:1000] !busy) else $error("busy never fell");
endmodule

// ### dv/sar_adc_parallel_conversion_port_test.sv
`include "adc_port_regs.svh"
module sar_adc_parallel_conversion_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_port_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we  = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    bus_word_t   sample_r = 12'h000;
    logic        auto_pd_r = 1'b0;
    logic [11:0] ctrl;
    logic [1:0]  chan;
    logic        tracking;
    logic        powered;
    int          miscompares = 0;
    int          checked = 0;
    int          cycles = 0;

    adc_port_if bus_if ();
    adc_port_dev #(.RES_BITS(12)) adc_port_dev_i (.clk_i(clk), .rst_i(rst), .port(bus_if), .sample_i(sample_r),
        .auto_power_down_i(auto_pd_r), .ctrl_o(ctrl), .channel_o(chan), .tracking_o(tracking), .powered_o(powered));
    adc_port_host adc_port_host_i (.clk_i(clk), .rst_i(rst), .port(bus_if), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack));
    adc_port_props adc_port_props_i (.clk_i(clk), .rst_i(rst), .data_bus(bus_if.data_bus),
        .data_from_dev(bus_if.data_from_dev), .data_oe_n_dev(bus_if.data_oe_n_dev), .word_mode(bus_if.word_mode),
        .chip_select_n(bus_if.chip_select_n), .read_n(bus_if.read_n), .write_n(bus_if.write_n),
        .conversion_start_n(bus_if.conversion_start_n), .master_clock_in(bus_if.master_clock_in),
        .busy(bus_if.busy));

    initial begin
        forever #20 clk = ~clk;
    end

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb_cycle(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        // Waits for ack; if ack never comes, only the bench ceiling ends this wait
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_idle();
        logic [31:0] s;
        int n;
        repeat (2) @(posedge clk);
        for (n = 0; n < 500; n++) begin
            wb_cycle(1'b0, `HOST_REG_STATUS, 32'h0, s);
            if (s[2:0] === 3'b000) break;
        end
        check("status idle", 32'h0, {29'h0, s[2:0]});
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic test_reset();
        check("busy", 32'h0, {31'h0, bus_if.busy});
        check("dev oe_n", 32'hFFF, {20'h0, bus_if.data_oe_n_dev});
        check("tracking", 32'h1, {31'h0, tracking});
        check("powered", 32'h1, {31'h0, powered});
        check("ctrl", 32'h0, {20'h0, ctrl});
        $display("test reset done");
    endtask

    task automatic test_convert(input bus_word_t value, input logic word, input logic [1:0] id);
        logic [31:0] q;
        sample_r <= value;
        wb_cycle(1'b1, `HOST_REG_CTRL, 32'h11 | (32'(word) << 3), q);
        repeat (3) @(posedge clk);
        check("tracking in conversion", 32'h0, {31'h0, tracking});
        check("busy in conversion", 32'h1, {31'h0, bus_if.busy});
        wait_idle();
        check("tracking after conversion", 32'h1, {31'h0, tracking});
        check("busy after conversion", 32'h0, {31'h0, bus_if.busy});
        wb_cycle(1'b1, `HOST_REG_CTRL, 32'h12 | (32'(word) << 3), q);
        wait_idle();
        wb_cycle(1'b0, `HOST_REG_RESULT, 32'h0, q);
        check("result", {20'h0, value}, {20'h0, q[11:0]});
        check("channel out", {30'h0, id}, {30'h0, chan});
        if (!word) check("channel id", {30'h0, id}, {30'h0, q[13:12]});
        $display("test convert done");
    endtask

    task automatic test_write(input logic [11:0] value, input logic word);
        logic [31:0] q;
        wb_cycle(1'b1, `HOST_REG_WDATA, {20'h0, value}, q);
        wb_cycle(1'b1, `HOST_REG_CTRL, 32'h14 | (32'(word) << 3), q);
        wait_idle();
        check("control register", {20'h0, value}, {20'h0, ctrl});
        $display("test write done");
    endtask

    task automatic test_power();
        logic [31:0] q;
        auto_pd_r <= 1'b1;
        test_convert(12'h5A3, 1'b0, 2'h1);
        check("powered down", 32'h0, {31'h0, powered});
        wb_cycle(1'b1, `HOST_REG_CTRL, 32'h30, q);
        wait_idle();
        check("woken", 32'h1, {31'h0, powered});
        auto_pd_r <= 1'b0;
        $display("test power done");
    endtask

    initial begin
        do_reset();
        test_reset();
        test_convert(12'hA5C, 1'b1, 2'h0);
        test_convert(12'h3F1, 1'b0, 2'h0);
        test_convert(12'hFFF, 1'b1, 2'h0);
        test_write(12'h0A5, 1'b1);
        test_write(12'h3C5, 1'b0);
        test_power();
        // Second reset in mid-run must clear everything again
        do_reset();
        test_reset();
        report_and_stop();
    end
endmodule
